// ==== shared/lfs_pkg.sv ====
package lfs_pkg;

    // ****************************************
    // Clock and interval lengths
    // ****************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int DET_MASK_NS = 10000;
    localparam int REL_MASK_NS = 10000;
    localparam int COOLDOWN_NS = 200000;
    localparam int SHORT_DEGLITCH_NS = 20000;
    localparam int FREQUENCY_SET_PIN_SETTLE_NS = 2000;

    // Least times round up to whole cycles
    localparam int DET_MASK_CYC = (DET_MASK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REL_MASK_CYC = (REL_MASK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int COOLDOWN_CYC = (COOLDOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SHORT_DEGLITCH_CYC = (SHORT_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FREQUENCY_SET_PIN_SETTLE_CYC = (FREQUENCY_SET_PIN_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

    // ****************************************
    // Peak current limit hit counter
    // ****************************************
    localparam int PEAK_W = 4;
    localparam logic [PEAK_W-1:0] PEAK_LATCH_COUNT = 4'h9;
    localparam logic [PEAK_W-1:0] PEAK_ZERO = 4'h0;
    localparam logic [PEAK_W-1:0] PEAK_ONE = 4'h1;

    // ****************************************
    // Pin vector positions
    // ****************************************
    localparam int NPIN = 15;
    localparam int PIN_EN = 0;
    localparam int PIN_SUPPLY = 1;
    localparam int PIN_THR = 2;
    localparam int PIN_DIM = 3;
    localparam int PIN_LED_OPEN = 4;
    localparam int PIN_IND_OPEN = 5;
    localparam int PIN_BATT = 6;
    localparam int PIN_SENSE = 7;
    localparam int PIN_PEAK = 8;
    localparam int PIN_FOPEN = 9;
    localparam int PIN_FSHORT = 10;
    localparam int PIN_TOVER = 11;
    localparam int PIN_TCOOL = 12;
    localparam int PIN_SLOW = 13;
    localparam int PIN_SHIGH = 14;
    localparam logic [NPIN-1:0] PIN_RESET = 15'h0000;

    // ****************************************
    // Hiccup state machine
    // ****************************************
    typedef enum logic [3:0] {
        LFS_RUN = 4'h1,
        LFS_MASK = 4'h2,
        LFS_HICCUP = 4'h4,
        LFS_RELEASE = 4'h8
    } lfs_state_type;

endpackage : lfs_pkg

// ==== shared/lfs_pin_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface lfs_pin_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface : lfs_pin_if
`default_nettype wire

// ==== hdl/lfs_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
module lfs_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Pins in, qualified levels out
    lfs_pin_if.sync pins
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] clean_reg;
    wire [W-1:0] agree = ~(s2_reg ^ s3_reg);
    wire [W-1:0] clean_next = (agree & s3_reg) | (~agree & clean_reg);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s1_reg <= INIT;
            s2_reg <= INIT;
            s3_reg <= INIT;
            clean_reg <= INIT;
        end
        else
        begin
            s1_reg <= pins.raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            clean_reg <= clean_next;
        end
    end

    assign pins.clean = clean_reg;
endmodule : lfs_sync
`default_nettype wire

// ==== hdl/lfs_supervisor.sv ====
// How it works
// - Open fault counts only with threshold input high and dim above 0.4V; hiccup after mask.
// - Open fault gone: resume at hiccup end, flag high after release mask.
// - Every hiccup holds switching off for the full cool-down count.
// - Inductor open and short to battery behave exactly like open fault.
// - Sense short without peak limit: hiccup after mask, flag low.
// - Sense short cleared: resume at hiccup end, needs threshold and dim qualified.
// - Ninth peak current limit hit latches off at once, flag low.
// - Peak latch clears on enable rising with peak condition removed, or on supply power-up.
// - Frequency pin tested once after every supply power-up.
// - Frequency pin fault latches off until next power-up; enable ignored.
// - Overtemperature stops switching; restart once below threshold minus hysteresis.
// - Regulators stay on during overtemperature; only switching stops.
// - Output short flags low after deglitch, clears at once above 1.8V.
`timescale 1ns/1ns
`default_nettype none
module lfs_supervisor
    import lfs_pkg::*;
#(
    parameter int DET_MASK = lfs_pkg::DET_MASK_CYC,
    parameter int REL_MASK = lfs_pkg::REL_MASK_CYC,
    parameter int COOLDOWN = lfs_pkg::COOLDOWN_CYC,
    parameter int SHORT_DEGLITCH = lfs_pkg::SHORT_DEGLITCH_CYC,
    parameter int FREQUENCY_SET_PIN_SETTLE = lfs_pkg::FREQUENCY_SET_PIN_SETTLE_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Board control
    input wire logic enable_pin,
    input wire logic supply_good,
    input wire logic open_detect_threshold_input,
    input wire logic analog_dim_input,
    // Fault comparators
    input wire logic led_open_cmp,
    input wire logic inductor_open_cmp,
    input wire logic short_to_battery_cmp,
    input wire logic sense_short_cmp,
    input wire logic peak_limit_hit,
    input wire logic frequency_set_pin_open,
    input wire logic frequency_set_pin_short,
    input wire logic thermal_over_cmp,
    input wire logic thermal_cool_cmp,
    input wire logic output_low_cmp,
    input wire logic output_high_cmp,
    // Status and control out
    output logic fault_n,
    output logic switching_on,
    output logic regulator_on,
    output logic hiccup_active,
    output logic peak_latched,
    output logic frequency_set_pin_latched,
    output logic thermal_shutdown,
    output logic output_short
);
    import lfs_pkg::*;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    lfs_pin_if #(.W(NPIN)) pins ();
    assign pins.raw = {output_high_cmp, output_low_cmp, thermal_cool_cmp, thermal_over_cmp,
                       frequency_set_pin_short, frequency_set_pin_open, peak_limit_hit,
                       sense_short_cmp, short_to_battery_cmp, inductor_open_cmp,
                       led_open_cmp, analog_dim_input, open_detect_threshold_input,
                       supply_good, enable_pin};

    lfs_sync #(.W(NPIN), .INIT(PIN_RESET)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .pins(pins)
    );

    wire [NPIN-1:0] p = pins.clean;
    logic en_prev_reg;
    logic sup_prev_reg;
    logic peak_prev_reg;
    wire en_rise = p[PIN_EN] & ~en_prev_reg;
    wire powerup = p[PIN_SUPPLY] & ~sup_prev_reg;
    wire peak_rise = p[PIN_PEAK] & ~peak_prev_reg;

    // ****************************************
    // Fault qualification
    // ****************************************
    wire qualified = p[PIN_THR] & p[PIN_DIM];
    wire open_like = p[PIN_LED_OPEN] | p[PIN_IND_OPEN] | p[PIN_BATT];
    wire open_fault = qualified & open_like;
    wire sense_fault = qualified & p[PIN_SENSE] & ~p[PIN_PEAK];
    wire hiccup_cause = open_fault | sense_fault;

    // ****************************************
    // Hiccup state machine
    // ****************************************
    lfs_state_type state_reg;
    lfs_state_type state_next;
    logic [CNT_W-1:0] timer_reg;
    logic [CNT_W-1:0] timer_next;
    logic sense_kind_reg;
    logic sense_kind_next;
    wire timer_done = (timer_reg == CNT_ZERO);
    wire [CNT_W-1:0] timer_dec = timer_reg - CNT_ONE;
    // Sense short may only leave hiccup when qualified again
    wire may_resume = ~hiccup_cause & (~sense_kind_reg | qualified);

    always_comb
    begin
        state_next = state_reg;
        timer_next = timer_done ? timer_reg : timer_dec;
        sense_kind_next = sense_kind_reg;
        case (state_reg)
            LFS_RUN:
            begin
                if (hiccup_cause)
                begin
                    state_next = LFS_MASK;
                    timer_next = DET_MASK[CNT_W-1:0];
                end
            end
            LFS_MASK:
            begin
                if (!hiccup_cause)
                    state_next = LFS_RUN;
                else if (timer_done)
                begin
                    state_next = LFS_HICCUP;
                    timer_next = COOLDOWN[CNT_W-1:0];
                    sense_kind_next = sense_fault;
                end
            end
            LFS_HICCUP:
            begin
                if (timer_done)
                begin
                    if (may_resume)
                    begin
                        state_next = LFS_RELEASE;
                        timer_next = REL_MASK[CNT_W-1:0];
                    end
                    else
                    begin
                        timer_next = COOLDOWN[CNT_W-1:0];
                        // Sense kind sticks while unqualified, so it cannot slip out
                        sense_kind_next = sense_kind_reg | sense_fault;
                    end
                end
            end
            LFS_RELEASE:
            begin
                if (hiccup_cause)
                begin
                    state_next = LFS_MASK;
                    timer_next = DET_MASK[CNT_W-1:0];
                end
                else if (timer_done)
                    state_next = LFS_RUN;
            end
            default:
            begin
                state_next = LFS_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= LFS_RUN;
            timer_reg <= CNT_ZERO;
            sense_kind_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            sense_kind_reg <= sense_kind_next;
        end
    end

    // ****************************************
    // Peak current limit latch
    // ****************************************
    logic [PEAK_W-1:0] peak_cnt_reg;
    logic peak_latch_reg;
    wire peak_clear = (en_rise & ~p[PIN_PEAK]) | powerup;
    wire peak_trip = peak_rise & (peak_cnt_reg == PEAK_LATCH_COUNT - PEAK_ONE);
    wire [PEAK_W-1:0] peak_cnt_next = peak_clear ? PEAK_ZERO :
                                      (peak_rise & ~peak_latch_reg) ? peak_cnt_reg + PEAK_ONE :
                                      peak_cnt_reg;

    // ****************************************
    // Frequency pin check
    // ****************************************
    logic [CNT_W-1:0] fcnt_reg;
    logic fcheck_reg;
    logic frequency_set_pin_latch_reg;
    wire frequency_set_pin_bad = p[PIN_FOPEN] | p[PIN_FSHORT];
    wire fcheck_end = fcheck_reg & (fcnt_reg == CNT_ZERO);

    // ****************************************
    // Thermal and output short
    // ****************************************
    logic hot_reg;
    logic [CNT_W-1:0] scnt_reg;
    logic short_reg;
    wire hot_next = p[PIN_TOVER] | (hot_reg & ~p[PIN_TCOOL]);
    wire short_set = p[PIN_SLOW] & (scnt_reg == CNT_ONE);
    wire short_next = ~p[PIN_SHIGH] & (short_set | short_reg);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            en_prev_reg <= 1'b0;
            sup_prev_reg <= 1'b0;
            peak_prev_reg <= 1'b0;
            peak_cnt_reg <= PEAK_ZERO;
            peak_latch_reg <= 1'b0;
            fcnt_reg <= CNT_ZERO;
            fcheck_reg <= 1'b0;
            frequency_set_pin_latch_reg <= 1'b0;
            hot_reg <= 1'b0;
            scnt_reg <= CNT_ZERO;
            short_reg <= 1'b0;
        end
        else
        begin
            en_prev_reg <= p[PIN_EN];
            sup_prev_reg <= p[PIN_SUPPLY];
            peak_prev_reg <= p[PIN_PEAK];
            peak_cnt_reg <= peak_cnt_next;
            // Trip wins over a clear in the same cycle
            peak_latch_reg <= peak_trip | (peak_latch_reg & ~peak_clear);
            if (powerup)
            begin
                fcheck_reg <= 1'b1;
                fcnt_reg <= FREQUENCY_SET_PIN_SETTLE[CNT_W-1:0];
                frequency_set_pin_latch_reg <= 1'b0;
            end
            else if (fcheck_end)
            begin
                fcheck_reg <= 1'b0;
                frequency_set_pin_latch_reg <= frequency_set_pin_bad;
            end
            else if (fcheck_reg)
                fcnt_reg <= fcnt_reg - CNT_ONE;
            hot_reg <= hot_next;
            scnt_reg <= !p[PIN_SLOW] ? SHORT_DEGLITCH[CNT_W-1:0] :
                        (scnt_reg == CNT_ZERO) ? scnt_reg : scnt_reg - CNT_ONE;
            short_reg <= short_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    wire hiccup_flag = (state_reg == LFS_HICCUP) | (state_reg == LFS_RELEASE);
    wire fault_any = hiccup_flag | peak_latch_reg | frequency_set_pin_latch_reg | hot_reg | short_reg;
    // Power-up edge also holds off, before the check flag is up
    wire run_ok = p[PIN_EN] & p[PIN_SUPPLY] & ~fcheck_reg & ~powerup & ~frequency_set_pin_latch_reg
                  & ~peak_latch_reg & ~hot_reg
                  & (state_reg != LFS_HICCUP);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            fault_n <= 1'b1;
            switching_on <= 1'b0;
            regulator_on <= 1'b0;
            hiccup_active <= 1'b0;
            peak_latched <= 1'b0;
            frequency_set_pin_latched <= 1'b0;
            thermal_shutdown <= 1'b0;
            output_short <= 1'b0;
        end
        else
        begin
            fault_n <= ~fault_any;
            switching_on <= run_ok;
            regulator_on <= p[PIN_EN] & p[PIN_SUPPLY];
            hiccup_active <= (state_reg == LFS_HICCUP);
            peak_latched <= peak_latch_reg;
            frequency_set_pin_latched <= frequency_set_pin_latch_reg;
            thermal_shutdown <= hot_reg;
            output_short <= short_reg;
        end
    end
endmodule : lfs_supervisor
`default_nettype wire

// ==== testbench/lfs_supervisor_props.sv ====
`timescale 1ns/1ns
`default_nettype none
module lfs_supervisor_props
    import lfs_pkg::*;
#(
    parameter int DET_MASK = 8,
    parameter int COOLDOWN = 30,
    parameter int SHORT_DEGLITCH = 10
) (
    // Clock and reset
    input wire logic sys_clk, rst,
    // Board and comparators
    input wire logic enable_pin, supply_good, open_detect_threshold_input, analog_dim_input,
    input wire logic led_open_cmp, inductor_open_cmp, short_to_battery_cmp, sense_short_cmp,
    input wire logic peak_limit_hit, frequency_set_pin_open, frequency_set_pin_short,
    input wire logic thermal_over_cmp, thermal_cool_cmp, output_low_cmp, output_high_cmp,
    // Status
    input wire logic fault_n, switching_on, regulator_on, hiccup_active,
    input wire logic peak_latched, frequency_set_pin_latched, thermal_shutdown, output_short
);
    // ****************************************
    // Hiccup length counter
    // ****************************************
    logic [CNT_W-1:0] hic_cnt_reg;
    wire logic any_open = led_open_cmp | inductor_open_cmp | short_to_battery_cmp;
    wire logic cause_ok = (any_open | sense_short_cmp) & open_detect_threshold_input
        & analog_dim_input;
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            hic_cnt_reg <= CNT_ZERO;
        else
            hic_cnt_reg <= hiccup_active ? hic_cnt_reg + CNT_ONE : CNT_ZERO;
    end
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    property stopped(s);
        s |-> !switching_on && !fault_n;
    endproperty
    AST_HICCUP_STOP: assert property (stopped(hiccup_active))
        else $error("hiccup while switching");
    AST_PEAK_STOP: assert property (stopped(peak_latched))
        else $error("peak latch while switching");
    AST_FREQUENCY_SET_PIN_STOP: assert property (stopped(frequency_set_pin_latched))
        else $error("frequency_set_pin latch while switching");
    AST_THERM_STOP: assert property (stopped(thermal_shutdown))
        else $error("thermal stop while switching");
    AST_MASK_CAUSE: assert property ($rose(hiccup_active) |-> $past(cause_ok, DET_MASK))
        else $error("hiccup without masked cause");
    AST_COOL_LEN: assert property ($fell(hiccup_active) |-> hic_cnt_reg >= COOLDOWN)
        else $error("cool-down too short");
    AST_REL_MASK: assert property ($fell(hiccup_active) |-> (switching_on && !fault_n) [*8])
        else $error("flag released early");
    AST_REG_KEEP: assert property ($rose(thermal_shutdown) |-> $stable(regulator_on))
        else $error("regulators dropped");
    AST_THERM_BACK: assert property ((thermal_cool_cmp && !thermal_over_cmp) [*8]
        |-> !thermal_shutdown)
        else $error("no thermal restart");
    AST_SHORT_GLITCH: assert property ($rose(output_short) |->
        $past(output_low_cmp, SHORT_DEGLITCH) && $stable(switching_on))
        else $error("short flagged early");
    AST_SHORT_CLR: assert property (output_high_cmp [*8] |-> !output_short)
        else $error("short flag held");
    COV_HICCUP: cover property ($rose(hiccup_active));
    COV_PEAK: cover property ($rose(peak_latched));
    COV_SHORT: cover property ($rose(output_short));
endmodule : lfs_supervisor_props
bind lfs_supervisor lfs_supervisor_props #(.DET_MASK(DET_MASK), .COOLDOWN(COOLDOWN),
    .SHORT_DEGLITCH(SHORT_DEGLITCH)) u_props (.*);
`default_nettype wire

// ==== testbench/lfs_board_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module lfs_board_model (
    // Clock
    input wire logic sys_clk,
    // Control from bench
    input wire logic thr_gnd, pk_go, pk_hold,
    input wire logic [3:0] npk, gap,
    // Board pins
    output logic open_detect_threshold_input,
    output logic peak_limit_hit
);
    logic pk_q = 1'h0;
    // Divider tied to ground or supply, never floating
    assign open_detect_threshold_input = !thr_gnd;
    assign peak_limit_hit = pk_q | pk_hold;
    // Burst of current-limited switching cycles
    always @(posedge pk_go)
    begin
        repeat (npk)
        begin
            repeat (4) @(negedge sys_clk);
            pk_q = 1'h1;
            repeat (4 + gap) @(negedge sys_clk);
            pk_q = 1'h0;
        end
    end
endmodule : lfs_board_model
`default_nettype wire

// ==== testbench/test_led_driver_fault_supervisor.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_led_driver_fault_supervisor;
    import lfs_pkg::*;
    logic sys_clk, rst, enable_pin, supply_good, analog_dim_input, thr_gnd, pk_go, pk_hold;
    logic frequency_set_pin_open, frequency_set_pin_short, thermal_over_cmp, thermal_cool_cmp;
    logic output_low_cmp, output_high_cmp, open_detect_threshold_input, peak_limit_hit;
    logic fault_n, switching_on, regulator_on, hiccup_active;
    logic peak_latched, frequency_set_pin_latched, thermal_shutdown, output_short;
    logic [3:0] cz, npk, gap;
    wire logic led_open_cmp = cz[0];
    wire logic inductor_open_cmp = cz[1];
    wire logic short_to_battery_cmp = cz[2];
    wire logic sense_short_cmp = cz[3];
    wire logic [7:0] st = {fault_n, switching_on, regulator_on, hiccup_active,
        peak_latched, frequency_set_pin_latched, thermal_shutdown, output_short};
    int miscompares = 0;
    int cmp_count = 0;
    int seed = 32'haf53;
    lfs_supervisor #(.DET_MASK(8), .REL_MASK(8), .COOLDOWN(30), .SHORT_DEGLITCH(10),
        .FREQUENCY_SET_PIN_SETTLE(6)) DUT (.*);
    lfs_board_model PM (.*);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] ex(input logic h, p, f, t, s);
        ex = {!(h | p | f | t | s), !(h | p | f | t), 1'h1, h, p, f, t, s};
    endfunction : ex
    task chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
            miscompares++;
        end
    endtask : chk
    task wt(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : wt
    task done_test(input string n);
        $display("test %s finished", n);
        wt(4 + {$random(seed)} % 8);
    endtask : done_test
    task summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    task fault_case(input int i);
        cz[i] = 1'h1;
        wt(20);
        chk(st, ex(1, 0, 0, 0, 0));
        wt(40);
        chk(st, ex(1, 0, 0, 0, 0));
        cz[i] = 1'h0;
        wt(21);
        chk(st, 8'h60);
        wt(15);
        chk(st, ex(0, 0, 0, 0, 0));
    endtask : fault_case
    task burst(input logic [3:0] n, input int w);
        npk = n;
        gap = 4'($random(seed));
        pk_go = 1'h1;
        wt(1);
        pk_go = 1'h0;
        wt(w);
    endtask : burst
    task power;
        supply_good = 1'h0;
        wt(10);
        supply_good = 1'h1;
        wt(25);
    endtask : power
    task toggle_en;
        enable_pin = 1'h0;
        wt(10);
        enable_pin = 1'h1;
        wt(15);
    endtask : toggle_en
    // ****************************************
    // Clock, watchdog and tests
    // ****************************************
    initial
    begin
        sys_clk = 1'h0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial
    begin
        repeat (6000) @(posedge sys_clk);
        miscompares++;
        summarize();
    end
    initial
    begin
        {rst, enable_pin, supply_good, analog_dim_input, thr_gnd, pk_go, pk_hold} = 7'h48;
        {frequency_set_pin_open, frequency_set_pin_short, thermal_over_cmp} = 3'h0;
        {thermal_cool_cmp, output_low_cmp, output_high_cmp} = 3'h1;
        {cz, npk, gap} = 12'h000;
        wt(3);
        chk(st, 8'h80);
        wt(3);
        rst = 1'h0;
        {enable_pin, supply_good} = 2'h3;
        wt(25);
        chk(st, ex(0, 0, 0, 0, 0));
        done_test("reset");
        for (int i = 0; i < 4; i++)
            fault_case(i);
        cz[3] = 1'h1;
        wt(20);
        chk(st, ex(1, 0, 0, 0, 0));
        {analog_dim_input, cz} = 5'h00;
        wt(60);
        chk(st, ex(1, 0, 0, 0, 0));
        analog_dim_input = 1'h1;
        wt(55);
        chk(st, ex(0, 0, 0, 0, 0));
        {analog_dim_input, cz} = 5'h01;
        wt(30);
        chk(st, ex(0, 0, 0, 0, 0));
        {analog_dim_input, thr_gnd} = 2'h3;
        wt(30);
        chk(st, ex(0, 0, 0, 0, 0));
        {thr_gnd, cz} = 5'h00;
        done_test("hiccup");
        burst(8, 200);
        chk(st, ex(0, 0, 0, 0, 0));
        burst(1, 40);
        chk(st, ex(0, 1, 0, 0, 0));
        pk_hold = 1'h1;
        toggle_en();
        chk(st, ex(0, 1, 0, 0, 0));
        pk_hold = 1'h0;
        toggle_en();
        chk(st, ex(0, 0, 0, 0, 0));
        burst(8, 200);
        chk(st, ex(0, 0, 0, 0, 0));
        done_test("peak");
        for (int i = 0; i < 2; i++)
        begin
            {frequency_set_pin_short, frequency_set_pin_open} = 2'h1 << i;
            wt(20);
            chk(st, ex(0, 0, 0, 0, 0));
            power();
            chk(st, ex(0, 0, 1, 0, 0));
            toggle_en();
            chk(st, ex(0, 0, 1, 0, 0));
            {frequency_set_pin_short, frequency_set_pin_open} = 2'h0;
            power();
            chk(st, ex(0, 0, 0, 0, 0));
        end
        done_test("frequency_set_pin");
        {thermal_over_cmp, thermal_cool_cmp} = 2'h2;
        wt(10);
        chk(st, ex(0, 0, 0, 1, 0));
        thermal_over_cmp = 1'h0;
        wt(10);
        chk(st, ex(0, 0, 0, 1, 0));
        thermal_cool_cmp = 1'h1;
        wt(10);
        chk(st, ex(0, 0, 0, 0, 0));
        done_test("thermal");
        {output_low_cmp, output_high_cmp} = 2'h2;
        wt(8);
        chk(st, ex(0, 0, 0, 0, 0));
        wt(12);
        chk(st, ex(0, 0, 0, 0, 1));
        {output_low_cmp, output_high_cmp} = 2'h1;
        wt(8);
        chk(st, ex(0, 0, 0, 0, 0));
        done_test("short");
        summarize();
    end
endmodule : test_led_driver_fault_supervisor
`default_nettype wire
